// [alarm_pkg.sv]
// Package for the supply alarm indicator encoder: register map, fields, reset values, timing.
// Assumes a single 125 MHz clock domain.
package alarm_pkg;
    // Register offsets
    localparam logic [7:0] OFF_COND = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MASK = 8'h08;
    localparam logic [7:0] OFF_CTRL = 8'h0C;
    localparam logic [7:0] OFF_NVM_ADDR = 8'h10;
    localparam logic [7:0] OFF_NVM_DATA = 8'h14;
    // Condition and status bit positions
    localparam int BIT_NOIN = 0;
    localparam int BIT_OVERVOLT = 1;
    localparam int BIT_OC = 2;
    localparam int BIT_OTW = 3;
    localparam int BIT_OTF = 4;
    localparam int BIT_RESTART = 5;
    localparam int EVT_W = 6;
    // Control bit positions
    localparam int CTRL_LATCH_EN = 0;
    // Reset values
    localparam logic [5:0] MASK_RST = 6'h00;
    localparam logic [0:0] CTRL_RST = 1'h1;
    // Nonvolatile store
    localparam int NVM_BYTES = 96;
    // Timing: least off time before latch-off restart
    localparam int CLK_HZ = 125_000_000;
    localparam int OFF_MIN_S = 2;
    localparam longint OFF_MIN_CYC = longint'(OFF_MIN_S) * longint'(CLK_HZ);
    // Lamp colour encoding
    typedef enum logic [1:0] {LAMP_OFF, LAMP_GREEN, LAMP_RED} lamp_e;
endpackage : alarm_pkg

// [sync2.sv]
// Two flip-flop synchroniser for a bus of pin levels.
// Assumes the inputs are asynchronous to clk_sys_in.
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter int W = 1
) (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r;
    always_ff @(posedge clk_sys_in)
    begin
        if (!reset_n_in)
        begin
            meta_r <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule : sync2
`default_nettype wire

// [nvm_store.sv]
// Host-usable byte store, flip-flop backed, modelling the nonvolatile area.
// Assumes one-cycle write strobe and registered read data.
`timescale 1ns/1ps
`default_nettype none
module nvm_store #(
    parameter int DEPTH = alarm_pkg::NVM_BYTES,
    parameter int AW = 7
) (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic [AW-1:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    output logic [7:0] rdata_out
);
    logic [7:0] mem_r [DEPTH];
    wire in_range = 32'(addr_in) < DEPTH;
    // Contents survive controller reset, as a nonvolatile store would
    always_ff @(posedge clk_sys_in)
    begin
        if (wr_in && in_range)
            mem_r[addr_in] <= wdata_in;
    end
    always_ff @(posedge clk_sys_in)
    begin
        if (!reset_n_in)
            rdata_out <= 8'h00;
        else
            rdata_out <= in_range ? mem_r[addr_in] : 8'h00;
    end
endmodule : nvm_store
`default_nettype wire

// [alarm_encoder.sv]
// Alarm encoder: maps supply conditions onto lamps and monitor outputs, latch-off restart, host store.
// Assumes condition inputs and remote switch are asynchronous pins; register port on clk_sys_in.
`timescale 1ns/1ps
`default_nettype none
module alarm_encoder #(
    parameter longint OFF_MIN_CYC = alarm_pkg::OFF_MIN_CYC
) (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic input_lost_in,
    input wire logic overvoltage_protection_in,
    input wire logic overcurrent_in,
    input wire logic temp_warn_in,
    input wire logic temp_fault_in,
    input wire logic remote_power_switch_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    output logic irq_out,
    output logic [1:0] input_lamp_out,
    output logic [1:0] output_lamp_out,
    output logic [1:0] fault_lamp_out,
    output logic fault_n_out,
    output logic output_good_out,
    output logic input_good_out,
    output logic temp_good_out,
    output logic output_enable_out
);
    // --------------------------------------------------------------
    // Pin synchronisation
    // --------------------------------------------------------------
    logic [5:0] pins_s;
    sync2 #(.W(6)) u_sync (
        .clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in),
        .async_in({remote_power_switch_in, temp_fault_in, temp_warn_in,
                   overcurrent_in, overvoltage_protection_in, input_lost_in}),
        .sync_out(pins_s)
    );
    wire noin = pins_s[0];
    wire overvolt = pins_s[1];
    wire oc = pins_s[2];
    wire otw = pins_s[3];
    wire otf = pins_s[4];
    wire sw_on = pins_s[5];

    // --------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------
    logic [alarm_pkg::EVT_W-1:0] status_r;
    logic [alarm_pkg::EVT_W-1:0] status_nxt;
    logic [alarm_pkg::EVT_W-1:0] mask_r;
    logic [0:0] ctrl_r;
    logic [6:0] nvm_addr_r;
    logic latched_r;
    logic sw_prev_r;
    logic [31:0] off_cnt_r;
    logic [4:0] cond_prev_r;
    logic [31:0] rdata_r;
    logic rd_nvm_r;
    logic [7:0] nvm_rdata;

    wire sel_cond = addr_in == alarm_pkg::OFF_COND;
    wire sel_status = addr_in == alarm_pkg::OFF_STATUS;
    wire sel_mask = addr_in == alarm_pkg::OFF_MASK;
    wire sel_ctrl = addr_in == alarm_pkg::OFF_CTRL;
    wire sel_naddr = addr_in == alarm_pkg::OFF_NVM_ADDR;
    wire sel_ndata = addr_in == alarm_pkg::OFF_NVM_DATA;
    wire latch_en = ctrl_r[alarm_pkg::CTRL_LATCH_EN];

    // --------------------------------------------------------------
    // Latch-off and restart
    // --------------------------------------------------------------
    wire [4:0] cond = {otf, otw, oc, overvolt, noin};
    // Only shutdown faults latch; a warning keeps output on
    wire trip = overvolt | oc | otf;
    wire off_long = 64'(off_cnt_r) >= OFF_MIN_CYC;
    // restart needs the off time; shorter pulses ignored
    wire restart = latched_r && sw_on && !sw_prev_r && off_long;
    always_ff @(posedge clk_sys_in)
    begin
        if (!reset_n_in)
        begin
            latched_r <= 1'b0;
            sw_prev_r <= 1'b0;
            off_cnt_r <= 32'h0000_0000;
        end
        else
        begin
            sw_prev_r <= sw_on;
            if (sw_on)
                off_cnt_r <= 32'h0000_0000;
            else if (!off_long)
                off_cnt_r <= off_cnt_r + 32'h0000_0001;
            if (restart)
                latched_r <= 1'b0;
            else if (trip && latch_en)
                latched_r <= 1'b1;
        end
    end
    assign output_enable_out = sw_on && !latched_r && !trip && !noin;

    // --------------------------------------------------------------
    // Lamp and monitor encoding
    // --------------------------------------------------------------
    // any condition but a temperature warning, or a latch-off, forces output fault state
    wire out_bad = noin | overvolt | oc | otf | latched_r;
    wire any_alarm = out_bad | otw;
    // temp fault or warning drops temp_good_out alike
    wire temp_bad = otf | otw;
    // normal state green, all monitors high
    // no input: input lamp and input_good off
    wire [1:0] in_lamp = noin ? 2'(alarm_pkg::LAMP_OFF) : 2'(alarm_pkg::LAMP_GREEN);
    // overvoltage drops output lamp and output_good
    // overcurrent drops output lamp and output_good
    wire [1:0] out_lamp = out_bad ? 2'(alarm_pkg::LAMP_OFF) : 2'(alarm_pkg::LAMP_GREEN);
    wire [1:0] flt_lamp = any_alarm ? 2'(alarm_pkg::LAMP_RED) : 2'(alarm_pkg::LAMP_OFF);
    always_ff @(posedge clk_sys_in)
    begin
        if (!reset_n_in)
        begin
            input_lamp_out <= 2'(alarm_pkg::LAMP_OFF);
            output_lamp_out <= 2'(alarm_pkg::LAMP_OFF);
            fault_lamp_out <= 2'(alarm_pkg::LAMP_OFF);
            fault_n_out <= 1'b1;
            output_good_out <= 1'b0;
            input_good_out <= 1'b0;
            temp_good_out <= 1'b1;
        end
        else
        begin
            input_lamp_out <= in_lamp;
            output_lamp_out <= out_lamp;
            fault_lamp_out <= flt_lamp;
            fault_n_out <= !any_alarm;
            output_good_out <= !out_bad;
            input_good_out <= !noin;
            temp_good_out <= !temp_bad;
        end
    end

    // --------------------------------------------------------------
    // Interrupt status: rising conditions and restarts
    // --------------------------------------------------------------
    wire [alarm_pkg::EVT_W-1:0] evt = {restart, cond & ~cond_prev_r};
    wire clr_status = rd_in && sel_status;
    // Set wins over a read clear in the same cycle
    assign status_nxt = (clr_status ? '0 : status_r) | evt;
    always_ff @(posedge clk_sys_in)
    begin
        if (!reset_n_in)
        begin
            status_r <= '0;
            cond_prev_r <= 5'h00;
        end
        else
        begin
            status_r <= status_nxt;
            cond_prev_r <= cond;
        end
    end
    assign irq_out = |(status_r & mask_r);

    // --------------------------------------------------------------
    // Register write and read
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys_in)
    begin
        if (!reset_n_in)
        begin
            mask_r <= alarm_pkg::MASK_RST;
            ctrl_r <= alarm_pkg::CTRL_RST;
            nvm_addr_r <= 7'h00;
        end
        else if (wr_in)
        begin
            if (sel_mask)
                mask_r <= wdata_in[alarm_pkg::EVT_W-1:0];
            else if (sel_ctrl)
                ctrl_r <= wdata_in[0:0];
            else if (sel_naddr)
                nvm_addr_r <= wdata_in[6:0];
        end
    end

    nvm_store #(.DEPTH(alarm_pkg::NVM_BYTES), .AW(7)) u_nvm (
        .clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in),
        .addr_in(nvm_addr_r),
        .wdata_in(wdata_in[7:0]),
        .wr_in(wr_in && sel_ndata),
        .rdata_out(nvm_rdata)
    );

    wire [31:0] rd_mux =
        sel_cond ? {25'h0, latched_r, sw_on, cond} :
        sel_status ? {26'h0, status_r} :
        sel_mask ? {26'h0, mask_r} :
        sel_ctrl ? {31'h0, ctrl_r} :
        sel_naddr ? {25'h0, nvm_addr_r} : 32'h0000_0000;
    always_ff @(posedge clk_sys_in)
    begin
        if (!reset_n_in)
        begin
            rdata_r <= 32'h0000_0000;
            rd_nvm_r <= 1'b0;
        end
        else
        begin
            rd_nvm_r <= rd_in && sel_ndata;
            rdata_r <= rd_in ? rd_mux : 32'h0000_0000;
        end
    end
    assign rdata_out = rd_nvm_r ? {24'h0, nvm_rdata} : rdata_r;
endmodule : alarm_encoder
`default_nettype wire

// [alarm_encoder_props.sv]
// Checker: alarm encoder monitor outputs against its condition pins.
// Assumes alarm_encoder port names; pin changes show 3 edges later.
`timescale 1ns/1ps
`default_nettype none
module alarm_checker (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic input_lost_in,
    input wire logic overvoltage_protection_in,
    input wire logic overcurrent_in,
    input wire logic temp_warn_in,
    input wire logic temp_fault_in,
    input wire logic rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic [1:0] output_lamp_out,
    input wire logic [1:0] fault_lamp_out,
    input wire logic fault_n_out,
    input wire logic output_good_out,
    input wire logic input_good_out,
    input wire logic temp_good_out,
    input wire logic output_enable_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    wire logic calm = !(input_lost_in | overvoltage_protection_in | overcurrent_in | temp_warn_in | temp_fault_in);
    no_input_a: assert property (input_lost_in [*4] |-> !input_good_out && !output_good_out)
        else $error("input loss not shown");
    lost_lamp_a: assert property (input_lost_in [*4] |-> fault_lamp_out == 2'h2)
        else $error("fault lamp dark on input loss");
    overvolt_out_a: assert property (overvoltage_protection_in [*4] |-> output_lamp_out == 2'h0)
        else $error("output lamp lit on overvoltage");
    overcur_mon_a: assert property (overcurrent_in [*4] |-> !output_good_out && !fault_n_out)
        else $error("overcurrent not shown");
    temp_warn_a: assert property (temp_warn_in [*4] |-> !temp_good_out && !fault_n_out)
        else $error("temperature warning not shown");
    hot_fault_a: assert property (temp_fault_in [*4] |-> !temp_good_out && !output_good_out)
        else $error("temperature fault not shown");
    normal_state_a: assert property (calm [*4] ##0 $past(output_enable_out) |-> fault_n_out && output_good_out)
        else $error("normal state not shown");
    rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
        else $error("read data outside read slot");
endmodule : alarm_checker
bind alarm_encoder alarm_checker alarm_checker_i (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .input_lost_in(input_lost_in), .overvoltage_protection_in(overvoltage_protection_in),
    .overcurrent_in(overcurrent_in), .temp_warn_in(temp_warn_in), .temp_fault_in(temp_fault_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .output_lamp_out(output_lamp_out), .fault_lamp_out(fault_lamp_out),
    .fault_n_out(fault_n_out), .output_good_out(output_good_out), .input_good_out(input_good_out),
    .temp_good_out(temp_good_out), .output_enable_out(output_enable_out));
`default_nettype wire

// [host_switch_model.sv]
// Host model: cycles the remote power switch off then on.
// Assumes one clock; off time in cycles, scaled down for simulation.
`timescale 1ns/1ps
`default_nettype none
module host_switch_model (
    input wire logic clk_sys_in,
    input wire logic go_in,
    input wire logic [7:0] off_cyc_in,
    output logic switch_out,
    output logic done_out
);
    initial
    begin
        switch_out = 1'b1;
        done_out = 1'b0;
        forever
        begin
            @(posedge clk_sys_in);
            if (go_in)
            begin
                switch_out <= 1'b0;
                repeat (off_cyc_in) @(posedge clk_sys_in);
                switch_out <= 1'b1;
                done_out <= 1'b1;
                @(posedge clk_sys_in);
                done_out <= 1'b0;
            end
        end
    end
endmodule : host_switch_model
`default_nettype wire

// [tb_top.sv]
// Testbench: lamp and monitor mapping, registers, store, latch-off restart.
// Assumes alarm_encoder built with a short off time.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_top;
    logic clk_sys_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [4:0] cond = 5'h00;
    logic [4:0] sticky = 5'h00;
    logic [7:0] addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic look = 1'b0;
    logic look_d = 1'b0;
    logic go = 1'b0;
    logic [7:0] off_cyc = 8'h00;
    logic [7:0] byte_v;
    logic [32:0] e;
    logic [32:0] exp_q[$];
    logic [4:0] codes[8] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h18, 5'h00};
    integer seed = 65;
    int num_errors = 0;
    int num_checks = 0;
    wire logic [31:0] rdata_out;
    wire logic irq_out, fault_n_out, output_good_out, input_good_out, temp_good_out, output_enable_out, sw, done;
    wire logic [1:0] input_lamp_out, output_lamp_out, fault_lamp_out;
    wire logic [31:0] pins = {21'h0, irq_out, input_lamp_out, output_lamp_out, fault_lamp_out,
        fault_n_out, output_good_out, input_good_out, temp_good_out};
    alarm_encoder #(.OFF_MIN_CYC(20)) alarm_encoder_i (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .input_lost_in(cond[0]), .overvoltage_protection_in(cond[1]), .overcurrent_in(cond[2]),
        .temp_warn_in(cond[3]), .temp_fault_in(cond[4]), .remote_power_switch_in(sw), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out),
        .input_lamp_out(input_lamp_out), .output_lamp_out(output_lamp_out), .fault_lamp_out(fault_lamp_out),
        .fault_n_out(fault_n_out), .output_good_out(output_good_out), .input_good_out(input_good_out),
        .temp_good_out(temp_good_out), .output_enable_out(output_enable_out));
    host_switch_model host_switch_model_i (.clk_sys_in(clk_sys_in), .go_in(go), .off_cyc_in(off_cyc),
        .switch_out(sw), .done_out(done));
    function automatic logic [31:0] exp_pins(input logic [4:0] c);
        logic trip;
        trip = c[0] | c[1] | c[2] | c[4];
        return {21'h0, sticky[0], c[0] ? 2'h0 : 2'h1, trip ? 2'h0 : 2'h1, (|c) ? 2'h2 : 2'h0,
            ~|c, !trip, !c[0], !(c[3] | c[4])};
    endfunction : exp_pins
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
    endtask : wr
    // Pin snapshot when k is set, register read otherwise
    task automatic chk(input logic k, input logic [7:0] a, input logic [31:0] x);
        @(posedge clk_sys_in);
        addr_in <= a;
        rd_in <= !k;
        look <= 1'b1;
        exp_q.push_back({k, x});
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        look <= 1'b0;
    endtask : chk
    task automatic set_cond(input logic [4:0] c);
        @(posedge clk_sys_in);
        sticky = sticky | (c & ~cond);
        cond <= c;
        repeat (4) @(posedge clk_sys_in);
    endtask : set_cond
    task automatic restart(input logic [7:0] n);
        @(posedge clk_sys_in);
        off_cyc <= n;
        go <= 1'b1;
        @(posedge clk_sys_in);
        go <= 1'b0;
        for (int i = 0; i < 300 && !done; i++) @(posedge clk_sys_in);
        repeat (4) @(negedge clk_sys_in);
    endtask : restart
    task automatic wrap_up;
        // Expectations never matched by a result count as mismatches
        num_errors += exp_q.size();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up
    always @(posedge clk_sys_in) look_d <= look;
    always @(negedge clk_sys_in)
        if (look_d && exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            if (e[32]) `CHK("pins", e[31:0], pins)
            else `CHK("rdata", e[31:0], rdata_out)
        end
    initial
    begin
        forever #4 clk_sys_in = ~clk_sys_in;
    end
    initial
    begin
        #100000;
        num_errors++;
        wrap_up();
    end
    initial
    begin
        repeat (3) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        chk(0, alarm_pkg::OFF_MASK, 32'h0);
        chk(0, alarm_pkg::OFF_CTRL, 32'h1);
        wr(alarm_pkg::OFF_CTRL, 32'h0);
        wr(alarm_pkg::OFF_MASK, 32'h1);
        chk(0, alarm_pkg::OFF_MASK, 32'h1);
        foreach (codes[i])
        begin
            set_cond(codes[i]);
            chk(1, 8'h00, exp_pins(codes[i]));
        end
        chk(0, alarm_pkg::OFF_STATUS, {27'h0, sticky});
        sticky = 5'h00;
        chk(0, alarm_pkg::OFF_STATUS, 32'h0);
        $display("table test done");
        byte_v = 8'($random(seed));
        wr(alarm_pkg::OFF_NVM_ADDR, 32'h5F);
        wr(alarm_pkg::OFF_NVM_DATA, {24'h0, byte_v});
        wr(alarm_pkg::OFF_NVM_ADDR, 32'h60);
        wr(alarm_pkg::OFF_NVM_DATA, 32'hA5);
        chk(0, alarm_pkg::OFF_NVM_DATA, 32'h0);
        wr(alarm_pkg::OFF_NVM_ADDR, 32'h5F);
        chk(0, alarm_pkg::OFF_NVM_DATA, {24'h0, byte_v});
        chk(0, 8'hFC, 32'h0);
        $display("store test done");
        repeat (8)
        begin
            set_cond(5'($random(seed)));
            chk(1, 8'h00, exp_pins(cond));
        end
        set_cond(5'h00);
        chk(0, alarm_pkg::OFF_STATUS, {27'h0, sticky});
        sticky = 5'h00;
        $display("random test done");
        wr(alarm_pkg::OFF_CTRL, 32'h1);
        set_cond(5'h04);
        set_cond(5'h00);
        restart(8'h05);
        `CHK("enable", 1'b0, output_enable_out)
        chk(0, alarm_pkg::OFF_COND, 32'h0000_0060);
        restart(8'h18);
        `CHK("enable", 1'b1, output_enable_out)
        chk(1, 8'h00, exp_pins(5'h00));
        chk(0, alarm_pkg::OFF_STATUS, {26'h0, 1'b1, sticky});
        chk(0, alarm_pkg::OFF_COND, 32'h0000_0020);
        $display("restart test done");
        // Let the watcher take the last result before the verdict
        repeat (2) @(posedge clk_sys_in);
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
